// *** rtl/ssp_pkg.sv ***
// Shared constants and state types for the serial port block
// ===========================================================
// Notes on behaviour
// - Transmit disable empties buffer, clears shifter
// - Receive disable keeps receive flags and data
// - Async clock output starts once selected
// - Enabled transmitter marks; receiver awaits start
// - Pending byte loads shifter, buffer marked empty
// - Frame: start, data LSB first, extra, stops
// - After stop: next byte or done flag
// - Receiver syncs on start, shifts LSB first
// - Parity checked; only first stop checked
// - Clean frame stored, buffer marked full
// - Frame into full buffer sets overrun, keeps old byte
// - Stop or parity error still stores byte
// - Error flags block reception and full flag
// - Receive full and error requests when enabled
// - Discard until matching identifier arrives
// - Multiprocessor format drops the parity bit
// - Sync: change on fall, sample on rise
// - Sync: eight bits, no extra bit
// - Sync internal clock: eight pulses, idle high
// - Async sample on eighth of sixteen ticks
package ssp_pkg;
   // ========================================================
   // Bit timing
   localparam logic [3:0] PH_LAST = 4'hf;
   localparam logic [3:0] PH_HIGH = 4'h8;
   localparam logic [3:0] PH_RISE = 4'h7;
   localparam logic [3:0] SAMPLE_TICK = 4'h7;
   localparam logic [3:0] DET_CNT = 4'h1;
   localparam logic [3:0] SYNC_BITS = 4'h8;
   localparam logic [3:0] SY_LAST = 4'h1;
   localparam logic [3:0] SY_IDLE = 4'h0;
   // ========================================================
   // Character layout and reset values
   localparam logic [2:0] LAST7 = 3'h6;
   localparam logic [2:0] LAST8 = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [7:0] MASK7 = 8'h7f;
   localparam logic [7:0] MASK8 = 8'hff;
   localparam logic [7:0] BUF_RST = 8'h00;
   // ========================================================
   // State types
   typedef enum logic [4:0] {
      TX_MARK = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_EXTRA = 5'h08, TX_STOP = 5'h10
   } ssp_tx_state_t;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_EXTRA = 5'h08, RX_STOP = 5'h10
   } ssp_rx_state_t;
endpackage : ssp_pkg

// *** rtl/ssp_sync2.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module ssp_sync2 #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // ========================================================
   // First stage feeds only the second stage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta <= '1; // Pins idle high, so no false edge after reset
         q <= '1;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : ssp_sync2

// *** rtl/ssp_clk_div.sv ***
// Baud divider giving a one-cycle enable at sixteen times the bit rate
`timescale 1ns/100ps
module ssp_clk_div #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] div,
   output logic tick
);
   logic [W-1:0] cnt;

   // ========================================================
   // Pulse once every div+1 clocks
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt >= div) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : ssp_clk_div

// *** rtl/ssp_serial_port.sv ***
// Serial port: async and sync transmitter, receiver and clock pin
`timescale 1ns/100ps
module ssp_serial_port #(
   parameter int DIV_W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic sync_mode,
   input wire logic char7,
   input wire logic parity_en,
   input wire logic parity_odd_sel,
   input wire logic mp_mode,
   input wire logic two_stop,
   input wire logic clk_src_ext,
   input wire logic clk_out_en,
   input wire logic [DIV_W-1:0] baud_divisor,
   input wire logic tx_write,
   input wire logic [7:0] tx_wdata,
   input wire logic addr_flag_tx,
   input wire logic rx_full_clr,
   input wire logic overrun_clr,
   input wire logic parity_clr,
   input wire logic frame_clr,
   input wire logic rx_irq_en,
   input wire logic tx_empty_irq_en,
   input wire logic tx_done_irq_en,
   input wire logic [7:0] own_id,
   input wire logic rxd,
   input wire logic sck_in,
   output logic txd,
   output logic sck_out,
   output logic sck_oe,
   output logic tx_buf_empty,
   output logic tx_done_flag,
   output logic rx_buf_full,
   output logic [7:0] rx_buf,
   output logic overrun_err,
   output logic parity_err,
   output logic frame_err,
   output logic addr_flag_bit,
   output logic mp_waiting,
   output logic tx_empty_irq,
   output logic tx_done_irq,
   output logic rx_full_irq,
   output logic rx_err_irq
);
   // ========================================================
   // Declarations
   ssp_pkg::ssp_tx_state_t tx_state;
   ssp_pkg::ssp_rx_state_t rx_state;
   logic [1:0] pin_s;
   logic rxd_s, sck_s, sck_d, sck_rise, sck_fall;
   logic div_tick, tick16, ph_end, sync_int, sy_bound, sy_demand;
   logic [3:0] ph, sy_bits, rx_cnt;
   logic [7:0] tx_buf, tx_shifter, rx_shifter, data_mask, rx_data;
   logic [2:0] data_last, tx_bitn, tx_bitn_nx, rx_bitn;
   logic tx_extra, tx_stopn, stop_last, has_extra, err_any;
   logic tx_step, tx_load_ok, tx_end_char, tx_take, tx_fin;
   logic bit_rise, rx_samp, rx_extra, stop_ok, rx_fin, rx_keep, par_bad, mp_active;

   // ========================================================
   // Pin synchronisers and clock sources
   ssp_sync2 #(.W(2)) u_pin_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d({sck_in, rxd}),
      .q(pin_s)
   );

   ssp_clk_div #(.W(DIV_W)) u_baud (
      .mclk(mclk),
      .rst_n(rst_n),
      .div(baud_divisor),
      .tick(div_tick)
   );

   assign rxd_s = pin_s[0];
   assign sck_s = pin_s[1];
   assign sck_rise = sck_s & ~sck_d;
   assign sck_fall = ~sck_s & sck_d;
   assign tick16 = (clk_src_ext & ~sync_mode) ? sck_rise : div_tick;
   assign ph_end = tick16 & (ph == ssp_pkg::PH_LAST);
   assign sync_int = sync_mode & ~clk_src_ext;
   assign sy_bound = ~sync_int | (sy_bits <= ssp_pkg::SY_LAST);

   // Previous clock pin level for edge finding
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sck_d <= 1'b1;
      end else begin
         sck_d <= sck_s;
      end
   end

   // Free-running bit phase, sixteen ticks per bit
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ph <= '0;
      end else if (tick16) begin
         ph <= ph + 4'h1;
      end
   end

   // ========================================================
   // Format decode
   assign err_any = overrun_err | parity_err | frame_err;
   assign data_last = (char7 & ~sync_mode) ? ssp_pkg::LAST7 : ssp_pkg::LAST8;
   assign data_mask = (char7 & ~sync_mode) ? ssp_pkg::MASK7 : ssp_pkg::MASK8;
   assign has_extra = ~sync_mode & (mp_mode | parity_en);
   assign mp_active = mp_mode & ~sync_mode;

   // ========================================================
   // Serial clock pin
   assign sy_demand = tx_load_ok | (rx_enable & ~err_any);

   // Character window of eight clock pulses in internal sync mode
   always_ff @(posedge mclk) begin
      if (!rst_n || !sync_int) begin
         sy_bits <= ssp_pkg::SY_IDLE;
      end else if (ph_end) begin
         if (sy_bits > ssp_pkg::SY_LAST) begin
            sy_bits <= sy_bits - 4'h1;
         end else begin
            sy_bits <= sy_demand ? ssp_pkg::SYNC_BITS : ssp_pkg::SY_IDLE;
         end
      end
   end

   // Drive clock pin: bit-rate clock in async, bursts in sync
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sck_oe <= 1'b0;
         sck_out <= 1'b1;
      end else begin
         sck_oe <= ~clk_src_ext & (sync_mode | clk_out_en);
         if (sync_mode && sy_bits == ssp_pkg::SY_IDLE) begin
            sck_out <= 1'b1;
         end else begin
            sck_out <= (ph >= ssp_pkg::PH_HIGH);
         end
      end
   end

   // ========================================================
   // Transmitter
   assign tx_step = (sync_mode & clk_src_ext) ? sck_fall : ph_end;
   assign tx_load_ok = tx_enable & ~tx_buf_empty & ~(sync_mode & err_any);
   assign stop_last = ~two_stop | tx_stopn;
   assign tx_end_char = (tx_state == ssp_pkg::TX_STOP && stop_last) ||
                        (sync_mode && tx_state == ssp_pkg::TX_DATA && tx_bitn == data_last);
   assign tx_take = tx_step & tx_load_ok &
                    ((tx_state == ssp_pkg::TX_MARK && sy_bound) || tx_end_char);
   assign tx_fin = tx_step & tx_enable & ~tx_load_ok & tx_end_char;
   assign tx_bitn_nx = tx_bitn + 3'h1;

   // Transmit sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n || !tx_enable) begin
         tx_state <= ssp_pkg::TX_MARK;
         txd <= 1'b1;
         tx_bitn <= ssp_pkg::BIT_FIRST;
         tx_stopn <= 1'b0;
      end else if (tx_take) begin
         tx_bitn <= ssp_pkg::BIT_FIRST;
         tx_stopn <= 1'b0;
         if (sync_mode) begin
            tx_state <= ssp_pkg::TX_DATA;
            txd <= tx_buf[0];
         end else begin
            tx_state <= ssp_pkg::TX_START;
            txd <= 1'b0;
         end
      end else if (tx_step) begin
         unique case (tx_state)
            ssp_pkg::TX_MARK: begin
               txd <= txd;
            end
            ssp_pkg::TX_START: begin
               tx_state <= ssp_pkg::TX_DATA;
               txd <= tx_shifter[0];
            end
            ssp_pkg::TX_DATA: begin
               if (tx_bitn == data_last) begin
                  if (sync_mode) begin
                     tx_state <= ssp_pkg::TX_MARK;
                  end else if (has_extra) begin
                     tx_state <= ssp_pkg::TX_EXTRA;
                     txd <= tx_extra;
                  end else begin
                     tx_state <= ssp_pkg::TX_STOP;
                     txd <= 1'b1;
                  end
               end else begin
                  tx_bitn <= tx_bitn_nx;
                  txd <= tx_shifter[tx_bitn_nx];
               end
            end
            ssp_pkg::TX_EXTRA: begin
               tx_state <= ssp_pkg::TX_STOP;
               txd <= 1'b1;
            end
            ssp_pkg::TX_STOP: begin
               if (!stop_last) begin
                  tx_stopn <= 1'b1;
               end else begin
                  tx_state <= ssp_pkg::TX_MARK;
               end
            end
         endcase
      end
   end

   // Shift register and parity or address flag
   always_ff @(posedge mclk) begin
      if (!rst_n || !tx_enable) begin
         tx_shifter <= ssp_pkg::BUF_RST;
         tx_extra <= 1'b1;
      end else if (tx_take) begin
         tx_shifter <= tx_buf & data_mask;
         if (mp_mode) begin
            tx_extra <= addr_flag_tx;
         end else begin
            tx_extra <= ^(tx_buf & data_mask) ^ parity_odd_sel;
         end
      end
   end

   // Transmit buffer and its flags, set beats clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_buf <= ssp_pkg::BUF_RST;
         tx_buf_empty <= 1'b1;
         tx_done_flag <= 1'b1;
      end else begin
         if (tx_write) begin
            tx_buf <= tx_wdata;
         end
         if (!tx_enable || tx_take) begin
            tx_buf_empty <= 1'b1;
         end else if (tx_write) begin
            tx_buf_empty <= 1'b0;
         end
         if (tx_fin) begin
            tx_done_flag <= 1'b1;
         end else if (tx_write) begin
            tx_done_flag <= 1'b0;
         end
      end
   end

   // ========================================================
   // Receiver
   assign bit_rise = clk_src_ext ? sck_rise
                                 : (tick16 & (ph == ssp_pkg::PH_RISE) & (sy_bits != ssp_pkg::SY_IDLE));
   assign rx_samp = sync_mode ? bit_rise
                              : (tick16 & (rx_cnt == ssp_pkg::SAMPLE_TICK) &
                                 (rx_state != ssp_pkg::RX_IDLE));

   // Receive sequencer, held idle while disabled or in error
   always_ff @(posedge mclk) begin
      if (!rst_n || !rx_enable || err_any) begin
         rx_state <= ssp_pkg::RX_IDLE;
         rx_cnt <= '0;
         rx_bitn <= ssp_pkg::BIT_FIRST;
      end else begin
         if (tick16) begin
            rx_cnt <= rx_cnt + 4'h1;
         end
         unique case (rx_state)
            ssp_pkg::RX_IDLE: begin
               if (sync_mode) begin
                  if (clk_src_ext || (ph_end && sy_bound)) begin
                     rx_state <= ssp_pkg::RX_DATA;
                     rx_bitn <= ssp_pkg::BIT_FIRST;
                  end
               end else if (tick16 && !rxd_s) begin
                  rx_state <= ssp_pkg::RX_START;
                  rx_cnt <= ssp_pkg::DET_CNT;
               end
            end
            ssp_pkg::RX_START: begin
               if (rx_samp) begin
                  rx_state <= rxd_s ? ssp_pkg::RX_IDLE : ssp_pkg::RX_DATA;
                  rx_bitn <= ssp_pkg::BIT_FIRST;
               end
            end
            ssp_pkg::RX_DATA: begin
               if (rx_samp) begin
                  if (rx_bitn == data_last) begin
                     rx_bitn <= ssp_pkg::BIT_FIRST;
                     if (!sync_mode) begin
                        rx_state <= has_extra ? ssp_pkg::RX_EXTRA : ssp_pkg::RX_STOP;
                     end
                  end else begin
                     rx_bitn <= rx_bitn + 3'h1;
                  end
               end
            end
            ssp_pkg::RX_EXTRA: begin
               if (rx_samp) begin
                  rx_state <= ssp_pkg::RX_STOP;
               end
            end
            ssp_pkg::RX_STOP: begin
               if (rx_samp) begin
                  rx_state <= ssp_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   // Receive shifter, extra bit, stop check and frame end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_shifter <= ssp_pkg::BUF_RST;
         rx_extra <= 1'b0;
         stop_ok <= 1'b1;
         rx_fin <= 1'b0;
      end else begin
         rx_fin <= rx_samp & rx_enable & ~err_any &
                   ((rx_state == ssp_pkg::RX_STOP) ||
                    (sync_mode && rx_state == ssp_pkg::RX_DATA && rx_bitn == data_last));
         if (rx_state == ssp_pkg::RX_START) begin
            rx_shifter <= ssp_pkg::BUF_RST;
         end else if (rx_samp && rx_state == ssp_pkg::RX_DATA) begin
            rx_shifter[rx_bitn] <= rxd_s;
         end
         if (rx_samp && rx_state == ssp_pkg::RX_EXTRA) begin
            rx_extra <= rxd_s;
         end
         if (sync_mode) begin
            stop_ok <= 1'b1;
         end else if (rx_samp && rx_state == ssp_pkg::RX_STOP) begin
            stop_ok <= rxd_s;
         end
      end
   end

   assign rx_data = rx_shifter & data_mask;
   assign par_bad = has_extra & ~mp_mode & (^rx_data ^ rx_extra ^ parity_odd_sel);
   assign rx_keep = rx_fin & ~(mp_active & (rx_extra | mp_waiting));

   // Receive buffer, status flags and address filter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rx_buf <= ssp_pkg::BUF_RST;
         rx_buf_full <= 1'b0;
         overrun_err <= 1'b0;
         parity_err <= 1'b0;
         frame_err <= 1'b0;
         addr_flag_bit <= 1'b0;
         mp_waiting <= 1'b1;
      end else begin
         if (rx_fin && mp_active) begin
            addr_flag_bit <= rx_extra;
         end
         if (!mp_active) begin
            mp_waiting <= 1'b1;
         end else if (rx_fin && rx_extra) begin
            mp_waiting <= (rx_data != own_id);
         end
         if (rx_keep && !rx_buf_full) begin
            rx_buf <= rx_data;
         end
         if (rx_keep && !rx_buf_full && stop_ok && !par_bad) begin
            rx_buf_full <= 1'b1;
         end else if (rx_full_clr) begin
            rx_buf_full <= 1'b0;
         end
         if (rx_keep && rx_buf_full) begin
            overrun_err <= 1'b1;
         end else if (overrun_clr) begin
            overrun_err <= 1'b0;
         end
         if (rx_keep && !stop_ok) begin
            frame_err <= 1'b1;
         end else if (frame_clr) begin
            frame_err <= 1'b0;
         end
         if (rx_keep && par_bad) begin
            parity_err <= 1'b1;
         end else if (parity_clr) begin
            parity_err <= 1'b0;
         end
      end
   end

   // ========================================================
   // Interrupt request levels
   assign tx_empty_irq = tx_buf_empty & tx_empty_irq_en;
   assign tx_done_irq = tx_done_flag & tx_done_irq_en;
   assign rx_full_irq = rx_buf_full & rx_irq_en;
   assign rx_err_irq = err_any & rx_irq_en;

   // ========================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_tx_disable_clears: assert property (!tx_enable |=> tx_buf_empty && txd &&
      tx_shifter == ssp_pkg::BUF_RST) else $error("transmit disable did not clear");
   a_rx_disable_holds: assert property ((!rx_enable && !rx_fin && !rx_full_clr &&
      !overrun_clr && !parity_clr && !frame_clr) |=> $stable(rx_buf) && $stable(rx_buf_full)
      && $stable(overrun_err) && $stable(parity_err) && $stable(frame_err))
      else $error("receive flags changed while disabled");
   a_clk_out_on: assert property ((!sync_mode && !clk_src_ext && clk_out_en) |=> sck_oe)
      else $error("async clock output not driven");
   a_tx_mark_idle: assert property ((tx_state == ssp_pkg::TX_MARK && !sync_mode &&
      $past(!sync_mode)) |-> txd) else $error("idle transmitter not at mark");
   a_tx_take_empty: assert property (tx_take |=> tx_buf_empty &&
      tx_shifter == $past(tx_buf & data_mask)) else $error("load did not empty buffer");
   a_tx_frame_bits: assert property ((tx_state == ssp_pkg::TX_START |-> !txd) and
      (tx_state == ssp_pkg::TX_STOP |-> txd)) else $error("start or stop level wrong");
   a_tx_done_set: assert property (tx_fin |=> tx_done_flag &&
      tx_state == ssp_pkg::TX_MARK) else $error("done flag not set");
   a_rx_store_ok: assert property ((rx_keep && !rx_buf_full && stop_ok && !par_bad) |=>
      rx_buf_full && rx_buf == $past(rx_data)) else $error("clean frame not stored");
   a_rx_overrun: assert property ((rx_keep && rx_buf_full) |=> overrun_err &&
      $stable(rx_buf)) else $error("overrun not flagged or buffer overwritten");
   a_rx_frame_err: assert property ((rx_keep && !stop_ok && !rx_buf_full) |=> frame_err &&
      !rx_buf_full && rx_buf == $past(rx_data)) else $error("framing error handling wrong");
   a_rx_err_block: assert property (err_any |=> rx_state == ssp_pkg::RX_IDLE ##1
      (!err_any || rx_state == ssp_pkg::RX_IDLE)) else $error("reception not blocked");
   a_sync_idle_high: assert property ((sync_int && sy_bits == ssp_pkg::SY_IDLE) |=>
      sck_out) else $error("sync clock not high when idle");

   c_tx_back_to_back: cover property (tx_take && tx_state == ssp_pkg::TX_STOP);
   c_rx_overrun: cover property (rx_keep && rx_buf_full);
   c_mp_match: cover property (mp_waiting ##1 !mp_waiting);
   c_sync_burst: cover property (sy_bits == ssp_pkg::SYNC_BITS);
endmodule : ssp_serial_port

// *** tb/ssp_far_node.sv ***
// Far serial node model: drives the receive line, captures frames from txd
`timescale 1ns/100ps
module ssp_far_node (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   // ====================================
   // Line idles at mark between frames
   initial rxd = 1'b1;
   // Send nb bits of fr LSB first, bc cycles each, then release to mark
   task automatic send(input logic [11:0] fr, input int nb, input int bc);
      for (int i = 0; i < nb; i++) begin
         @(posedge clk);
         rxd <= fr[i];
         repeat (bc - 1) @(posedge clk);
      end
      @(posedge clk);
      rxd <= 1'b1;
   endtask : send
   // Wait a bounded time for a start bit, then sample each bit at its centre
   task automatic recv(output logic [11:0] fr, input int nb, input int bc, input int lim);
      int n = 0;
      fr = '1; // Bits not captured read as mark
      while (txd !== 1'b0 && n < lim) begin
         @(posedge clk);
         n++;
      end
      for (int i = 0; i < nb; i++) begin
         repeat (i == 0 ? bc / 2 : bc) @(posedge clk);
         fr[i] = txd;
      end
   endtask : recv
endmodule : ssp_far_node

// *** tb/tb.sv ***
// Testbench for the serial port: frames both ways, flags and clock pin
`timescale 1ns/100ps
module tb;
   logic mclk = 1'b0, rst_n = 1'b0, sck_in = 1'b0;
   logic tx_enable, rx_enable, sync_mode, char7, parity_en, parity_odd_sel, mp_mode;
   logic two_stop, clk_src_ext, clk_out_en, tx_write, addr_flag_tx, rx_irq_en, rxd;
   logic rx_full_clr, overrun_clr, parity_clr, frame_clr, tx_empty_irq_en, tx_done_irq_en;
   logic [7:0] baud_divisor, tx_wdata, own_id, rx_buf;
   logic txd, sck_out, sck_oe, tx_buf_empty, tx_done_flag, rx_buf_full, overrun_err;
   logic parity_err, frame_err, addr_flag_bit, mp_waiting, tx_empty_irq, tx_done_irq;
   logic rx_full_irq, rx_err_irq;
   logic [11:0] f;
   int mismatches = 0, checked = 0, pulses = 0;
   // ====================================
   // Clocks, design and far node
   always #25 mclk = ~mclk;
   always #200 sck_in = ~sck_in;
   always @(posedge sck_out) pulses++;
   ssp_serial_port ssp_serial_port_i (.*);
   ssp_far_node ssp_far_node_i (.clk(mclk), .txd(txd), .rxd(rxd));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   task automatic wr(input logic [7:0] d);
      @(posedge mclk);
      tx_wdata <= d;
      tx_write <= 1'b1;
      @(posedge mclk);
      tx_write <= 1'b0;
   endtask : wr
   task automatic clr;
      @(posedge mclk);
      {rx_full_clr, overrun_clr, parity_clr, frame_clr} <= 4'hf;
      @(posedge mclk);
      {rx_full_clr, overrun_clr, parity_clr, frame_clr} <= 4'h0;
   endtask : clr
   // Start, eight data bits, extra bit, stops
   function automatic logic [11:0] fr8(input logic [7:0] d, input logic x);
      return {2'b11, x, d, 1'b0};
   endfunction : fr8
   task automatic rx(input logic [11:0] fr);
      ssp_far_node_i.send(fr, 11, 16);
      cyc(6);
   endtask : rx
   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (checked > 0 && mismatches == 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // Watchdog well beyond the expected run
   initial begin
      #3000000;
      mismatches++;
      stop_test;
   end
   // Test sequence
   initial begin
      {tx_enable, rx_enable, sync_mode, char7, mp_mode, two_stop, clk_src_ext} = 7'h00;
      {clk_out_en, parity_en, parity_odd_sel, tx_write, addr_flag_tx} = 5'h08;
      {rx_full_clr, overrun_clr, parity_clr, frame_clr} = 4'h0;
      {rx_irq_en, tx_empty_irq_en, tx_done_irq_en} = 3'h7;
      baud_divisor = 8'h00;
      tx_wdata = 8'h00;
      own_id = 8'h42;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      cyc(2);
      chk({txd, tx_buf_empty, rx_buf_full, sck_oe}, 12'hc, "reset state");
      @(posedge mclk);
      clk_out_en <= 1'b1;
      cyc(3);
      chk(sck_oe, 12'h1, "clock output");
      cyc(16);
      @(posedge mclk);
      {tx_enable, rx_enable} <= 2'b11;
      cyc(2);
      chk(txd, 12'h1, "mark");
      wr(8'ha5);
      cyc(1);
      repeat (40) if (tx_buf_empty !== 1'b1) cyc(1);
      chk(tx_empty_irq, 12'h1, "empty request");
      wr(8'h3c);
      ssp_far_node_i.recv(f, 11, 16, 40);
      chk(f, fr8(8'ha5, ^8'ha5), "first frame");
      ssp_far_node_i.recv(f, 11, 16, 40);
      chk(f, fr8(8'h3c, ^8'h3c), "second frame");
      chk(tx_done_flag, 12'h0, "done flag during frame");
      cyc(30);
      chk({tx_done_flag, tx_done_irq, txd}, 12'h7, "done");
      @(posedge mclk);
      {tx_enable, char7, two_stop, parity_odd_sel} <= 4'h7;
      cyc(16);
      @(posedge mclk);
      tx_enable <= 1'b1;
      wr(8'hb7);
      ssp_far_node_i.recv(f, 11, 16, 40);
      chk(f, fr8({~^7'h37, 7'h37}, 1'b1), "seven bit odd frame");
      chk(tx_done_flag, 12'h0, "second stop");
      cyc(30);
      chk(tx_done_flag, 12'h1, "two stops done");
      @(posedge mclk);
      {char7, two_stop, parity_odd_sel} <= 3'h0;
      $display("test transmit done");
      rx(fr8(8'h5a, ^8'h5a));
      chk({rx_buf_full, rx_full_irq, rx_buf}, 12'h35a, "stored");
      rx(fr8(8'h99, ^8'h99));
      chk({overrun_err, rx_err_irq, rx_buf}, 12'h35a, "overrun");
      clr;
      rx(fr8(8'h0f, ~^8'h0f));
      chk({parity_err, rx_buf_full, rx_buf}, 12'h20f, "parity");
      @(posedge mclk);
      rx_enable <= 1'b0;
      cyc(4);
      chk({parity_err, rx_buf}, 12'h10f, "kept");
      @(posedge mclk);
      rx_enable <= 1'b1;
      cyc(16);
      rx(fr8(8'h33, ^8'h33));
      chk({rx_buf_full, rx_buf}, 12'h00f, "blocked");
      clr;
      rx(fr8(8'h81, ^8'h81) & 12'h3ff);
      chk({frame_err, rx_buf_full, rx_buf}, 12'h281, "framing");
      clr;
      $display("test receive done");
      @(posedge mclk);
      mp_mode <= 1'b1;
      rx(fr8(8'h17, 1'b1));
      rx(fr8(8'h11, 1'b0));
      chk({mp_waiting, rx_buf_full}, 12'h2, "not ours");
      rx(fr8(8'h42, 1'b1));
      chk({mp_waiting, addr_flag_bit, rx_buf_full}, 12'h2, "id match");
      rx(fr8(8'h66, 1'b0));
      chk({mp_waiting, rx_buf_full, rx_buf}, 12'h166, "ours");
      clr;
      @(posedge mclk);
      addr_flag_tx <= 1'b1;
      wr(8'h42);
      ssp_far_node_i.recv(f, 11, 16, 40);
      chk(f, fr8(8'h42, 1'b1), "address frame");
      @(posedge mclk);
      {mp_mode, addr_flag_tx} <= 2'b00;
      wr(8'h00);
      cyc(60);
      @(posedge mclk);
      tx_enable <= 1'b0;
      cyc(2);
      chk({txd, tx_buf_empty}, 12'h3, "disable");
      @(posedge mclk);
      clk_src_ext <= 1'b1;
      cyc(130);
      chk(sck_oe, 12'h0, "clock input");
      @(posedge mclk);
      tx_enable <= 1'b1;
      wr(8'hc3);
      ssp_far_node_i.recv(f, 11, 128, 400);
      chk(f, fr8(8'hc3, ^8'hc3), "external clock frame");
      $display("test multiprocessor done");
      @(posedge mclk);
      {tx_enable, rx_enable, clk_src_ext, clk_out_en} <= 4'h0;
      cyc(2);
      @(posedge mclk);
      sync_mode <= 1'b1;
      cyc(16);
      @(posedge mclk);
      tx_enable <= 1'b1;
      pulses = 0;
      wr(8'h01);
      cyc(300);
      chk({pulses[3:0], sck_out, sck_oe, txd}, 12'h46, "sync burst");
      $display("test sync done");
      stop_test;
   end
endmodule : tb
